// >>> asti_pkg.sv
package asti_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [7:0] ASTI_IDX_ADC_NEG = 8'h05;
  localparam logic [7:0] ASTI_IDX_DAC_NEG = 8'h06;
  localparam logic [7:0] ASTI_IDX_FMT     = 8'h07;
  localparam logic [7:0] ASTI_IDX_BDIV    = 8'h08;
  localparam logic [7:0] ASTI_IDX_RATE    = 8'h0e;
  localparam logic [7:0] ASTI_IDX_TRI     = 8'h18;
  localparam logic [7:0] ASTI_IDX_ENA     = 8'h20;
  localparam logic [7:0] ASTI_IDX_STAT    = 8'h21;

  // Only whole-word transfers are accepted for writes.
  localparam logic [2:0] ASTI_HSIZE_WORD = 3'h2;

  // Field positions inside the registers.
  localparam int unsigned ASTI_NEG_RIGHT_BIT = 6;
  localparam int unsigned ASTI_NEG_LEFT_BIT  = 5;
  localparam int unsigned ASTI_TRI_BIT       = 3;
  localparam int unsigned ASTI_ENA_ADC_BIT   = 0;
  localparam int unsigned ASTI_ENA_DAC_BIT   = 1;
  localparam int unsigned ASTI_STAT_RUN_BIT  = 0;
  localparam int unsigned ASTI_STAT_SIDE_BIT = 1;
  localparam int unsigned ASTI_STAT_SEEN_BIT = 2;
  localparam int unsigned ASTI_FMT_W         = 13;
  localparam int unsigned ASTI_RATE_W        = 11;

  // Reset values.
  localparam logic [12:0] ASTI_FMT_RESET  = 13'h000a;
  localparam logic [3:0]  ASTI_BDIV_RESET = 4'h4;
  localparam logic [10:0] ASTI_RATE_RESET = 11'h040;
  localparam logic [1:0]  ASTI_NEG_RESET  = 2'h0;
  localparam logic [1:0]  ASTI_ENA_RESET  = 2'h0;
  localparam logic        ASTI_TRI_RESET  = 1'b0;

  // Real sample width and the smallest usable frame length in bit clocks.
  localparam logic [5:0]  ASTI_SAMPLE_W = 6'h18;
  localparam logic [10:0] ASTI_RATE_MIN = 11'h002;

  typedef enum logic [1:0] {
    ASTI_FMT_RJ  = 2'h0,
    ASTI_FMT_LJ  = 2'h1,
    ASTI_FMT_I2S = 2'h2,
    ASTI_FMT_DSP = 2'h3
  } asti_format_t;

  typedef enum logic [1:0] {
    ASTI_WL_16 = 2'h0,
    ASTI_WL_20 = 2'h1,
    ASTI_WL_24 = 2'h2,
    ASTI_WL_32 = 2'h3
  } asti_wlen_t;

  // Layout of the serial port format control register, bits 12 down to 0.
  typedef struct packed {
    logic         dac_slot_mux_enable;
    logic         dac_slot_select;
    logic         adc_slot_mux_enable;
    logic         adc_slot_select;
    logic         adc_channel_swap;
    logic         bit_clock_polarity;
    logic         clock_master_sel;
    logic         dac_channel_swap;
    logic         frame_clock_polarity;
    asti_wlen_t   word_length_sel;
    asti_format_t frame_format_sel;
  } asti_fmt_t;

  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } asti_pair_t;

  // Result of placing one bit-clock position inside the frame.
  typedef struct packed {
    logic       hit;
    logic       right;
    logic [5:0] idx;
  } asti_slot_t;

  typedef enum logic {
    ASTI_BUS_IDLE   = 1'b0,
    ASTI_BUS_RDWAIT = 1'b1
  } asti_bus_t;

endpackage

// >>> asti_top.sv
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Each direction has its own TDM enable: one stereo slot or two per frame.
// - With TDM, ADC data goes out only in its slot, DAC taken only from its slot.
// - With TDM, the ADC output floats before and after its own slot.
// - Beyond the real 24 data bits of a word the output is not driven.
// - With TDM the bit clock must be fast enough for both slots in a frame.
// - Right and left ADC negate controls, both cleared at reset.
// - Right and left DAC negate controls, both cleared at reset.
// - ADC channel swap exchanges left and right samples on the serial output.
// - DAC channel swap exchanges received left and right samples.
// - Bit clock polarity control inverts the bit clock, cleared at reset.
// - Frame clock polarity inverts frame clock, or picks DSP mode A or B.
// - Word length field selects 16, 20, 24 or 32 bits, reset 24.
// - Format field selects right, left, I2S or DSP framing, reset I2S.
// - Port float control releases data output and both clock pins, overriding all.
// - Clock master select: 0 slave at reset, 1 master driving both clocks.
// - A master drives the clocks only while an ADC or DAC is enabled.
// - A slave keeps its clock outputs off; the partner supplies both clocks.
// - Master bit clock is the processing clock divided by the ratio that the 4-bit code selects.
// - Master frame clock is bit clock divided by an 11-bit field, reset 64.
// - Left justified: MSB on first rising bit clock after frame transition.
// - I2S: MSB on second rising bit clock after frame transition.
// - Right justified: LSB on last rising bit clock before frame transition.
// - With 32-bit words the lowest 8 bits are ignored or left undriven.
module asti_top
  import asti_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_bclk,
  output logic             o_bclk,
  output logic             o_bclk_oe,
  input  wire logic        i_lrclk,
  output logic             o_lrclk,
  output logic             o_lrclk_oe,
  output logic             o_adc_serial_out,
  output logic             o_adc_serial_out_oe,
  input  wire logic        i_dac_serial_in,
  input  wire asti_pair_t  i_adc_sample,
  output logic             o_adc_sample_take,
  output asti_pair_t       o_dac_sample,
  output logic             o_dac_sample_valid
);

  // Control registers.
  logic [1:0]  adc_neg_q;
  logic [1:0]  dac_neg_q;
  asti_fmt_t   fmt_q;
  logic [3:0]  bdiv_q;
  logic [10:0] rate_q;
  logic        tri_q;
  logic [1:0]  ena_q;

  // Bus tracking.
  asti_bus_t   bus_q;
  logic        wr_pend_q;
  logic [8:0]  wr_idx_q;
  logic [8:0]  rd_idx_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_val;
  logic        addr_phase;
  logic        addr_ok;

  // Synchronisers and edge events.
  logic [2:0]  bclk_s_q;
  logic [1:0]  lrclk_s_q;
  logic [1:0]  din_s_q;
  logic        s_rise_q;
  logic        s_fall_q;

  // Master clock generation.
  logic        use_master;
  logic        m_run;
  logic [5:0]  m_div;
  logic [5:0]  m_cnt_q;
  logic        m_bclk_q;
  logic        m_lr_q;
  logic        m_rise_q;
  logic        m_fall_q;
  logic [10:0] m_rate;
  logic [10:0] m_fc_q;
  logic [10:0] m_fc_n;

  // Frame tracking.
  logic        ev_rise;
  logic        ev_fall;
  logic        lr_lvl;
  logic        lr_prev_q;
  logic        is_dsp;
  logic        left_lvl;
  logic        trans;
  logic        frame_start;
  logic [11:0] kf_q;
  logic [11:0] k_n;
  logic [11:0] half_q;
  logic [11:0] half_n;
  logic        side_q;
  logic        side_n;
  logic        seen_q;
  logic [5:0]  wl_bits;
  asti_slot_t  tx_map;
  asti_slot_t  rx_map;

  // Sample paths.
  asti_pair_t  adc_hold_q;
  asti_pair_t  adc_neg_v;
  asti_pair_t  adc_new;
  asti_pair_t  adc_cur;
  asti_pair_t  rx_q;
  logic        dout_q;
  logic        doe_q;

  // Word length in bits from the two-bit field.
  always_comb begin
    case (fmt_q.word_length_sel)
      ASTI_WL_16: wl_bits = 6'h10;
      ASTI_WL_20: wl_bits = 6'h14;
      ASTI_WL_24: wl_bits = 6'h18;
      default:    wl_bits = 6'h20;
    endcase
  end

  // Bit clock divide ratio; reserved codes fall back to four, divide by one runs at two.
  always_comb begin
    case (bdiv_q)
      4'h0:    m_div = 6'h02;
      4'h2:    m_div = 6'h02;
      4'h3:    m_div = 6'h03;
      4'h6:    m_div = 6'h06;
      4'h7:    m_div = 6'h08;
      4'h9:    m_div = 6'h0c;
      4'ha:    m_div = 6'h10;
      4'hb:    m_div = 6'h18;
      4'hd:    m_div = 6'h20;
      4'he:    m_div = 6'h20;
      4'hf:    m_div = 6'h20;
      default: m_div = 6'h04;
    endcase
  end

  // Places bit-clock position k of the current half (or DSP frame) on a channel and bit.
  function automatic asti_slot_t slot_map(input asti_format_t f, input logic [5:0] wl,
                                          input logic tdm, input logic slot, input logic modeb,
                                          input logic [11:0] k, input logic side,
                                          input logic [11:0] hl);
    asti_slot_t  r;
    logic [12:0] w;
    logic [12:0] kk;
    logic [12:0] off;
    logic [12:0] span;
    logic [12:0] s;
    logic [12:0] base;
    w    = {7'h00, wl};
    kk   = {1'b0, k};
    off  = (tdm && slot) ? w : 13'h0000;
    span = tdm ? (w << 1) : w;
    r.right = side;
    case (f)
      ASTI_FMT_LJ:  s = 13'h0001 + off;
      ASTI_FMT_I2S: s = 13'h0002 + off;
      ASTI_FMT_RJ: begin
        if ({1'b0, hl} >= span) begin
          s = {1'b0, hl} - span + 13'h0001 + off;
        end else begin
          s = 13'h1fff;
        end
      end
      default: begin
        base = (modeb ? 13'h0001 : 13'h0002) + ((tdm && slot) ? (w << 1) : 13'h0000);
        if (kk >= base + w) begin
          s       = base + w;
          r.right = 1'b1;
        end else begin
          s       = base;
          r.right = 1'b0;
        end
      end
    endcase
    r.hit = (kk >= s) && (kk < s + w);
    r.idx = 6'(kk - s);
    return r;
  endfunction

  // Two's complement negation of a sample.
  function automatic logic [23:0] neg24(input logic en, input logic [23:0] x);
    return en ? 24'(~x + 24'h000001) : x;
  endfunction

  // Bus address phase qualification.
  assign addr_phase = i_hsel && i_htrans[1] && i_hready;
  assign addr_ok    = (i_haddr[31:10] == 22'h000000) && (i_haddr[1:0] == 2'h0);

  // Bus phase tracking; reads take one wait state so that a preceding write is seen.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      bus_q     <= ASTI_BUS_IDLE;
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 9'h000;
      rd_idx_q  <= 9'h000;
      hrdata_q  <= 32'h00000000;
    end else begin
      case (bus_q)
        ASTI_BUS_IDLE: begin
          wr_pend_q <= addr_phase && i_hwrite && (i_hsize == ASTI_HSIZE_WORD);
          wr_idx_q  <= {addr_ok, i_haddr[9:2]};
          if (addr_phase && !i_hwrite) begin
            bus_q    <= ASTI_BUS_RDWAIT;
            rd_idx_q <= {addr_ok, i_haddr[9:2]};
          end
        end
        default: begin
          wr_pend_q <= 1'b0;
          hrdata_q  <= rd_val;
          bus_q     <= ASTI_BUS_IDLE;
        end
      endcase
    end
  end

  assign o_hreadyout = (bus_q == ASTI_BUS_IDLE);
  assign o_hresp     = 1'b0;
  assign o_hrdata    = hrdata_q;

  // Register read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_val = 32'h00000000;
    if (!rd_idx_q[8]) begin
      rd_val = 32'h00000000;
    end else if (rd_idx_q[7:0] == ASTI_IDX_ADC_NEG) begin
      rd_val[ASTI_NEG_RIGHT_BIT] = adc_neg_q[1];
      rd_val[ASTI_NEG_LEFT_BIT]  = adc_neg_q[0];
    end else if (rd_idx_q[7:0] == ASTI_IDX_DAC_NEG) begin
      rd_val[ASTI_NEG_RIGHT_BIT] = dac_neg_q[1];
      rd_val[ASTI_NEG_LEFT_BIT]  = dac_neg_q[0];
    end else if (rd_idx_q[7:0] == ASTI_IDX_FMT) begin
      rd_val[ASTI_FMT_W-1:0] = fmt_q;
    end else if (rd_idx_q[7:0] == ASTI_IDX_BDIV) begin
      rd_val[3:0] = bdiv_q;
    end else if (rd_idx_q[7:0] == ASTI_IDX_RATE) begin
      rd_val[ASTI_RATE_W-1:0] = rate_q;
    end else if (rd_idx_q[7:0] == ASTI_IDX_TRI) begin
      rd_val[ASTI_TRI_BIT] = tri_q;
    end else if (rd_idx_q[7:0] == ASTI_IDX_ENA) begin
      rd_val[ASTI_ENA_ADC_BIT] = ena_q[0];
      rd_val[ASTI_ENA_DAC_BIT] = ena_q[1];
    end else if (rd_idx_q[7:0] == ASTI_IDX_STAT) begin
      rd_val[ASTI_STAT_RUN_BIT]  = m_run;
      rd_val[ASTI_STAT_SIDE_BIT] = side_q;
      rd_val[ASTI_STAT_SEEN_BIT] = seen_q;
    end
  end

  // Register writes in the data phase.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      adc_neg_q <= ASTI_NEG_RESET;
      dac_neg_q <= ASTI_NEG_RESET;
      fmt_q     <= asti_fmt_t'(ASTI_FMT_RESET);
      bdiv_q    <= ASTI_BDIV_RESET;
      rate_q    <= ASTI_RATE_RESET;
      tri_q     <= ASTI_TRI_RESET;
      ena_q     <= ASTI_ENA_RESET;
    end else if (wr_pend_q && wr_idx_q[8]) begin
      if (wr_idx_q[7:0] == ASTI_IDX_ADC_NEG) begin
        adc_neg_q <= {i_hwdata[ASTI_NEG_RIGHT_BIT], i_hwdata[ASTI_NEG_LEFT_BIT]};
      end else if (wr_idx_q[7:0] == ASTI_IDX_DAC_NEG) begin
        dac_neg_q <= {i_hwdata[ASTI_NEG_RIGHT_BIT], i_hwdata[ASTI_NEG_LEFT_BIT]};
      end else if (wr_idx_q[7:0] == ASTI_IDX_FMT) begin
        fmt_q <= asti_fmt_t'(i_hwdata[ASTI_FMT_W-1:0]);
      end else if (wr_idx_q[7:0] == ASTI_IDX_BDIV) begin
        bdiv_q <= i_hwdata[3:0];
      end else if (wr_idx_q[7:0] == ASTI_IDX_RATE) begin
        rate_q <= i_hwdata[ASTI_RATE_W-1:0];
      end else if (wr_idx_q[7:0] == ASTI_IDX_TRI) begin
        tri_q <= i_hwdata[ASTI_TRI_BIT];
      end else if (wr_idx_q[7:0] == ASTI_IDX_ENA) begin
        ena_q <= {i_hwdata[ASTI_ENA_DAC_BIT], i_hwdata[ASTI_ENA_ADC_BIT]};
      end
    end
  end

  // Pin synchronisers and slave edge events, delayed one cycle so the frame level is settled.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      bclk_s_q  <= 3'h0;
      lrclk_s_q <= 2'h0;
      din_s_q   <= 2'h0;
      s_rise_q  <= 1'b0;
      s_fall_q  <= 1'b0;
    end else begin
      bclk_s_q  <= {bclk_s_q[1:0], i_bclk};
      lrclk_s_q <= {lrclk_s_q[0], i_lrclk};
      din_s_q   <= {din_s_q[0], i_dac_serial_in};
      s_rise_q  <= ((bclk_s_q[1] ^ fmt_q.bit_clock_polarity) == 1'b1) &&
                   ((bclk_s_q[2] ^ fmt_q.bit_clock_polarity) == 1'b0);
      s_fall_q  <= ((bclk_s_q[1] ^ fmt_q.bit_clock_polarity) == 1'b0) &&
                   ((bclk_s_q[2] ^ fmt_q.bit_clock_polarity) == 1'b1);
    end
  end

  // Master role only when selected and the port is not floated.
  assign use_master = fmt_q.clock_master_sel && !tri_q;
  assign m_run      = use_master && (ena_q != 2'h0);
  assign m_rate     = (rate_q < ASTI_RATE_MIN) ? ASTI_RATE_MIN : rate_q;
  assign m_fc_n     = (m_fc_q >= m_rate - 11'h001) ? 11'h000 : m_fc_q + 11'h001;

  // Master bit clock divider from the processing clock.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !m_run) begin
      m_cnt_q  <= 6'h00;
      m_bclk_q <= 1'b0;
      m_rise_q <= 1'b0;
      m_fall_q <= 1'b0;
    end else begin
      m_cnt_q  <= (m_cnt_q >= m_div - 6'h01) ? 6'h00 : m_cnt_q + 6'h01;
      m_rise_q <= (m_cnt_q == m_div - 6'h01);
      m_fall_q <= (m_cnt_q == (m_div >> 1) - 6'h01);
      if (m_cnt_q == m_div - 6'h01) begin
        m_bclk_q <= 1'b1;
      end else if (m_cnt_q == (m_div >> 1) - 6'h01) begin
        m_bclk_q <= 1'b0;
      end
    end
  end

  // Master frame clock, changing with the falling bit clock edge.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !m_run) begin
      m_fc_q <= m_rate - 11'h001;
      m_lr_q <= 1'b0;
    end else if (m_cnt_q == (m_div >> 1) - 6'h01) begin
      m_fc_q <= m_fc_n;
      if (fmt_q.frame_format_sel == ASTI_FMT_DSP) begin
        m_lr_q <= (m_fc_n == 11'h000);
      end else if (fmt_q.frame_format_sel == ASTI_FMT_I2S) begin
        m_lr_q <= (m_fc_n >= (m_rate >> 1)) ^ fmt_q.frame_clock_polarity;
      end else begin
        m_lr_q <= (m_fc_n < (m_rate >> 1)) ^ fmt_q.frame_clock_polarity;
      end
    end
  end

  // Clock pins are driven only by a running master.
  assign o_bclk     = m_bclk_q ^ fmt_q.bit_clock_polarity;
  assign o_bclk_oe  = m_run;
  assign o_lrclk    = m_lr_q;
  assign o_lrclk_oe = m_run;

  // Common event stream for both roles.
  assign ev_rise  = use_master ? m_rise_q : s_rise_q;
  assign ev_fall  = use_master ? m_fall_q : s_fall_q;
  assign lr_lvl   = use_master ? m_lr_q : lrclk_s_q[1];
  assign is_dsp   = (fmt_q.frame_format_sel == ASTI_FMT_DSP);
  assign left_lvl = (lr_lvl ^ fmt_q.frame_clock_polarity) ==
                    (fmt_q.frame_format_sel != ASTI_FMT_I2S);
  assign trans    = is_dsp ? (lr_lvl && !lr_prev_q) : (lr_lvl != lr_prev_q);
  assign frame_start = ev_fall && trans && (is_dsp || left_lvl);
  assign k_n      = trans ? 12'h001 : ((kf_q == 12'hfff) ? kf_q : kf_q + 12'h001);
  assign half_n   = trans ? kf_q : half_q;
  assign side_n   = trans ? (!is_dsp && !left_lvl) : side_q;

  // Position of the next rising bit clock edge within the current half or frame.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      lr_prev_q <= 1'b0;
      kf_q      <= 12'h000;
      half_q    <= 12'h000;
      side_q    <= 1'b0;
      seen_q    <= 1'b0;
    end else if (ev_fall) begin
      lr_prev_q <= lr_lvl;
      kf_q      <= k_n;
      half_q    <= half_n;
      side_q    <= side_n;
      seen_q    <= seen_q || frame_start;
    end
  end

  // Bit placement for each direction with its own slot controls.
  assign tx_map = slot_map(fmt_q.frame_format_sel, wl_bits, fmt_q.adc_slot_mux_enable,
                           fmt_q.adc_slot_select, fmt_q.frame_clock_polarity,
                           k_n, side_n, half_n);
  assign rx_map = slot_map(fmt_q.frame_format_sel, wl_bits, fmt_q.dac_slot_mux_enable,
                           fmt_q.dac_slot_select, fmt_q.frame_clock_polarity,
                           kf_q, side_q, half_q);

  // Negated, then swapped ADC sample; a frame's first bit is sent from it directly.
  assign adc_neg_v = {neg24(adc_neg_q[0], i_adc_sample.left),
                      neg24(adc_neg_q[1], i_adc_sample.right)};
  assign adc_new   = fmt_q.adc_channel_swap ? asti_pair_t'({adc_neg_v.right, adc_neg_v.left})
                                            : adc_neg_v;
  assign adc_cur   = frame_start ? adc_new : adc_hold_q;

  // ADC samples are latched at frame start.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      adc_hold_q        <= '0;
      o_adc_sample_take <= 1'b0;
    end else begin
      o_adc_sample_take <= frame_start && ena_q[ASTI_ENA_ADC_BIT];
      if (frame_start && ena_q[ASTI_ENA_ADC_BIT]) begin
        adc_hold_q <= adc_new;
      end
    end
  end

  // Serial output bit and its enable, updated on the falling bit clock edge.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !ena_q[ASTI_ENA_ADC_BIT]) begin
      dout_q <= 1'b0;
      doe_q  <= 1'b0;
    end else if (ev_fall) begin
      if (tx_map.hit && (tx_map.idx < ASTI_SAMPLE_W)) begin
        dout_q <= tx_map.right ? adc_cur.right[5'(6'h17 - tx_map.idx)]
                               : adc_cur.left[5'(6'h17 - tx_map.idx)];
        doe_q  <= 1'b1;
      end else if (tx_map.hit) begin
        dout_q <= 1'b0;
        doe_q  <= 1'b0;
      end else begin
        dout_q <= 1'b0;
        doe_q  <= !fmt_q.adc_slot_mux_enable;
      end
    end
  end

  assign o_adc_serial_out    = dout_q;
  assign o_adc_serial_out_oe = doe_q && !tri_q;

  // DAC bits are taken on the rising bit clock edge; bits past 24 are ignored.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || frame_start) begin
      rx_q <= '0;
    end else if (ev_rise && rx_map.hit && (rx_map.idx < ASTI_SAMPLE_W)) begin
      if (rx_map.right) begin
        rx_q.right[5'(6'h17 - rx_map.idx)] <= din_s_q[1];
      end else begin
        rx_q.left[5'(6'h17 - rx_map.idx)] <= din_s_q[1];
      end
    end
  end

  // Received samples are swapped, then negated per DAC channel, at the next frame start.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_dac_sample       <= '0;
      o_dac_sample_valid <= 1'b0;
    end else begin
      o_dac_sample_valid <= frame_start && seen_q && ena_q[ASTI_ENA_DAC_BIT];
      if (frame_start && seen_q && ena_q[ASTI_ENA_DAC_BIT]) begin
        if (fmt_q.dac_channel_swap) begin
          o_dac_sample.left  <= neg24(dac_neg_q[0], rx_q.right);
          o_dac_sample.right <= neg24(dac_neg_q[1], rx_q.left);
        end else begin
          o_dac_sample.left  <= neg24(dac_neg_q[0], rx_q.left);
          o_dac_sample.right <= neg24(dac_neg_q[1], rx_q.right);
        end
      end
    end
  end

endmodule // asti_top

// >>> asti_props.sv
`timescale 1ns/1ps
module asti_props
  import asti_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_srst,
  input wire logic       i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic       i_hwrite,
  input wire logic       i_hready,
  input wire logic       o_hreadyout,
  input wire logic       o_hresp,
  input wire logic       o_bclk_oe,
  input wire logic       o_lrclk_oe,
  input wire logic       o_adc_serial_out_oe,
  input wire logic       o_adc_sample_take,
  input wire asti_pair_t o_dac_sample,
  input wire logic       o_dac_sample_valid
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);

  // Bus answers: one wait state on reads, none on writes, always OKAY.
  AST_HRESP_OKAY: assert property (!o_hresp)
    else $error("bus response not OKAY");
  AST_READ_WAIT: assert property (i_hsel && i_htrans[1] && i_hready && !i_hwrite
    |=> !o_hreadyout ##1 o_hreadyout) else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (i_hsel && i_htrans[1] && i_hready && i_hwrite
    |=> o_hreadyout) else $error("write was stalled");
  // Pin drivers stay off after reset and both clock pins share one direction.
  AST_RESET_QUIET: assert property ($past(i_srst) |-> !o_bclk_oe && !o_lrclk_oe
    && !o_adc_serial_out_oe) else $error("pin driven after reset");
  AST_CLK_OE_PAIR: assert property (o_bclk_oe == o_lrclk_oe)
    else $error("clock pin directions differ");
  // Sample handshakes are single pulses followed by at least three idle cycles.
  AST_TAKE_PULSE: assert property (o_adc_sample_take |=> !o_adc_sample_take [*3])
    else $error("sample take pulse too long");
  AST_VALID_PULSE: assert property (o_dac_sample_valid |=> !o_dac_sample_valid [*3])
    else $error("sample valid pulse too long");
  AST_DAC_HOLD: assert property (!o_dac_sample_valid |-> $stable(o_dac_sample))
    else $error("received sample changed without valid");
endmodule // asti_props

bind asti_top asti_props u_props (.*);

// >>> asti_partner.sv
`timescale 1ns/1ps
module asti_partner
  import asti_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_run,
  input  wire logic [3:0] i_lead,
  input  wire asti_pair_t i_tx,
  input  wire logic       i_adc,
  input  wire logic       i_adc_oe,
  output logic            o_bclk,
  output logic            o_lrclk,
  output logic            o_dac,
  output asti_pair_t      o_rx
);
  asti_pair_t acc = '0;
  int         n;
  int         b;

  initial begin
    o_bclk = 1'b0;
    o_lrclk = 1'b0;
    o_dac = 1'b0;
    o_rx = '0;
  end

  // Slave-side clocks, 64 bit clocks a frame, still while idle; data starts i_lead bits into a half.
  always begin
    @(posedge i_clk);
    if (i_run) begin
      for (int j = 0; j < 64; j++) begin
        n = j % 32 - int'(i_lead);
        b = (j < 32) ? 24 : 0;
        o_bclk <= 1'b0;
        o_lrclk <= (j < 32) ^ (i_lead == 4'h1);
        o_dac <= (n >= 0 && n < 24) ? i_tx[b + 23 - n] : ~o_dac;
        repeat (6) @(posedge i_clk);
        o_bclk <= 1'b1;
        if (n >= 0 && n < 24) acc[b + 23 - n] = i_adc_oe ? i_adc : 1'bx;
        repeat (6) @(posedge i_clk);
      end
      o_rx <= acc;
    end
  end
endmodule // asti_partner

// >>> asti_tb_top.sv
`timescale 1ns/1ps
module asti_tb_top;
  import asti_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        run = 1'b0;
  logic [3:0]  lead = 4'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = ASTI_HSIZE_WORD;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, rd;
  asti_pair_t  adc_s = '0;
  asti_pair_t  tx = '0;
  asti_pair_t  rx, dac_o;
  logic        hrdy, hresp, bclk_o, bclk_oe, lr_o, lr_oe, ado, ado_oe, take, dval;
  logic        p_bclk, p_lr, p_dac;
  int          fails = 0;
  int          n_compared = 0;
  int          seed = 96;
  time         t;
  logic [31:0] ra[7] = '{32'h14, 32'h18, 32'h1c, 32'h20, 32'h38, 32'h60, 32'h3c};
  logic [31:0] rv[7] = '{32'h0, 32'h0, 32'ha, 32'h4, 32'h40, 32'h0, 32'h0};
  logic [3:0]  dc[7] = '{4'h2, 4'h3, 4'h4, 4'h7, 4'h9, 4'hb, 4'he};
  int          dv[7] = '{2, 3, 4, 8, 12, 24, 32};
  wire logic   bclk_w = bclk_oe ? bclk_o : p_bclk;
  wire logic   lr_w = lr_oe ? lr_o : p_lr;

  always #20 clk = ~clk;

  asti_top u_dut (.i_sys_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hrdy),
    .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_bclk(bclk_w), .o_bclk(bclk_o), .o_bclk_oe(bclk_oe), .i_lrclk(lr_w),
    .o_lrclk(lr_o), .o_lrclk_oe(lr_oe), .o_adc_serial_out(ado),
    .o_adc_serial_out_oe(ado_oe), .i_dac_serial_in(p_dac), .i_adc_sample(adc_s),
    .o_adc_sample_take(take), .o_dac_sample(dac_o), .o_dac_sample_valid(dval));

  asti_partner u_partner (.i_clk(clk), .i_run(run), .i_lead(lead), .i_tx(tx), .i_adc(ado),
    .i_adc_oe(ado_oe), .o_bclk(p_bclk), .o_lrclk(p_lr), .o_dac(p_dac), .o_rx(rx));

  // Expected sample after per-channel negation and after a left/right exchange.
  function automatic asti_pair_t ng(asti_pair_t s, logic [1:0] m);
    return {m[0] ? -s.left : s.left, m[1] ? -s.right : s.right};
  endfunction
  function automatic asti_pair_t sw(asti_pair_t s, logic e);
    return e ? {s.right, s.left} : s;
  endfunction

  // One single AHB-Lite transfer; ready and read data are taken at the rising edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog against a hang in any wait.
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    give_verdict();
  end

  // Main sequence: reset values, clock generation, float, then data in three formats.
  initial begin
    int p;
    logic [1:0] na, nd;
    logic asw, dsw;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], '0);
      check("reset value", rd, rv[i]);
    end
    bus(1'b1, 32'h1c, 32'h8a);
    repeat (2) @(posedge clk);
    check("idle bit clock", bclk_o, 1'b1);
    for (int f = 0; f < 16; f++) begin
      bus(1'b1, 32'h1c, 32'h40 | f);
      bus(1'b0, 32'h1c, '0);
      check("format", rd, 32'h40 | f);
      check("clocks held", bclk_oe, 1'b0);
    end
    bus(1'b1, 32'h80, 32'h1);
    foreach (dc[i]) begin
      bus(1'b1, 32'h20, dc[i]);
      repeat (2) @(posedge bclk_o);
      t = $time;
      @(posedge bclk_o);
      check("bit clock period", ($time - t) / 40, dv[i]);
    end
    p = 8 + {$random(seed)} % 32;
    bus(1'b1, 32'h38, p);
    bus(1'b1, 32'h20, 32'h2);
    repeat (2) @(posedge lr_o);
    t = $time;
    @(posedge lr_o);
    check("frame period", ($time - t) / 80, p);
    check("master drives", {bclk_oe, lr_oe}, 2'h3);
    bus(1'b1, 32'h60, 32'h8);
    repeat (2) @(posedge clk);
    check("float", {bclk_oe, lr_oe, ado_oe}, 3'h0);
    bus(1'b1, 32'h60, 32'h0);
    bus(1'b1, 32'h80, 32'h0);
    bus(1'b1, 32'h20, 32'h4);
    for (int i = 0; i < 3; i++) begin
      {na, nd, asw, dsw} = i ? 6'($random(seed)) : 6'h0;
      lead <= (i == 2) ? 4'h8 : 4'(i);
      adc_s <= 48'({$random(seed), $random(seed)});
      tx <= 48'({$random(seed), $random(seed)});
      bus(1'b1, 32'h14, {na, 5'h0});
      bus(1'b1, 32'h18, {nd, 5'h0});
      bus(1'b1, 32'h1c, {asw, 2'h0, dsw, 1'b0, 2'h2, (i == 2) ? 2'h0 : 2'(i + 1)});
      bus(1'b1, 32'h80, 32'h3);
      run <= 1'b1;
      repeat (3200) @(posedge clk);
      run <= 1'b0;
      repeat (800) @(posedge clk);
      check("adc serial", rx, sw(ng(adc_s, na), asw));
      check("dac sample", dac_o, ng(sw(tx, dsw), nd));
    end
    give_verdict();
  end
endmodule // asti_tb_top
